//--- src/asfc_top.sv
// Frame-level control of the 16-channel serial converter, with APB registers
//
// Summary of operation
// - Frame select falling edge samples the selected channel and starts a frame.
// - Output word is 4-bit channel address then 12-bit result, MSB first.
// - Input-read enable from previous frame swaps pin status into the address field.
// - Multiplexer moves to the new channel on the second serial clock fall.
// - Acquisition runs from the fourteenth clock rise to the next frame start.
// - Output pins take data received in the previous frame at frame start.
// - Input pin levels are latched at frame start and sent in that frame.
// - First address bit leaves at frame start, the rest on falls one to three.
// - Result MSB leaves on the fourth fall, LSB on the fifteenth.
// - Sixteenth fall ends the conversion and releases the serial output.
// - A 16-bit command is taken on each rising clock from the first.
// - Serial output is released once frame select returns high.
// - Per-channel high and low limits raise alarms on pin zero or one.
// - Alarm goes active on the twelfth fall of the frame that outputs the result.
// - Alarm clears on the tenth fall of the following frame.
// - Each general pin is an input or an output; only pins zero and one have a function, their alarm.
// - After reset the block is in manual sequencing on channel zero.
// - Channel written in one frame is selected in the following frame.
// - The first result after reset is invalid.
//
// Decided for this implementation: register access over APB and the address map.
`timescale 1ns/1ps
`include "asfc_defines.svh"
module asfc_top #(
    parameter int NPINS = 4,
    parameter int NCH   = 16
) (
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic [7:0]        paddr,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire logic              frame_select_n,
    input  wire logic              sclk,
    input  wire logic              sdi,
    output logic                   sdo,
    output logic                   sdo_oe,
    input  wire logic [NPINS-1:0]  gpio_in,
    output logic      [NPINS-1:0]  gpio_out,
    output logic      [NPINS-1:0]  gpio_oe,
    input  wire logic [11:0]       conv_result,
    output logic                   sample_pulse,
    output logic                   conv_busy,
    output logic                   acquire,
    output logic      [3:0]        mux_channel,
    output logic                   range_sel
);

    // ****************************************************************
    // Pin synchronisers and edge detection
    // ****************************************************************
    logic [2:0]                   link_s;
    logic [NPINS-1:0]             pin_s;
    logic                         fs_s;
    logic                         sclk_s;
    logic                         sdi_s;
    logic                         fs_d_r;
    logic                         sclk_d_r;
    logic                         fs_fall;
    logic                         fs_rise;
    logic                         sck_rise;
    logic                         sck_fall;
    asfc_pkg::asfc_frame_state_t  state_r;

    asfc_sync #(.WIDTH(3), .RST_VAL(3'h5)) u_link_sync (
        .clk   (pclk),
        .rst_n (presetn),
        .d     ({frame_select_n, sclk, sdi}),
        .q     (link_s)
    );

    asfc_sync #(.WIDTH(NPINS), .RST_VAL('0)) u_pin_sync (
        .clk   (pclk),
        .rst_n (presetn),
        .d     (gpio_in),
        .q     (pin_s)
    );

    assign fs_s   = link_s[2];
    assign sclk_s = link_s[1];
    assign sdi_s  = link_s[0];

    // Delayed copies of the synchronised levels for edge finding
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fs_d_r   <= 1'b1;
            sclk_d_r <= 1'b1;
        end else begin
            fs_d_r   <= fs_s;
            sclk_d_r <= sclk_s;
        end
    end

    // Clock edges only count while a frame is open
    assign fs_fall  = fs_d_r & ~fs_s;
    assign fs_rise  = ~fs_d_r & fs_s;
    assign sck_rise = ~sclk_d_r & sclk_s & (state_r != asfc_pkg::FRM_IDLE) & ~fs_fall;
    assign sck_fall = sclk_d_r & ~sclk_s & (state_r != asfc_pkg::FRM_IDLE) & ~fs_fall;

    // ****************************************************************
    // Frame sequencing and edge counters
    // ****************************************************************
    logic [4:0]  rise_cnt_r;
    logic [4:0]  fall_cnt_r;

    // Frame state follows the select line; sixteen falls close the shift
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r <= asfc_pkg::FRM_IDLE;
        end else if (fs_fall) begin
            state_r <= asfc_pkg::FRM_SHIFT;
        end else if (fs_rise) begin
            state_r <= asfc_pkg::FRM_IDLE;
        end else if (sck_fall && fall_cnt_r == `ASFC_FALL_END - 5'h01) begin
            state_r <= asfc_pkg::FRM_WAIT;
        end
    end

    // Counters saturate at sixteen; extra clocks in a frame are ignored
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rise_cnt_r <= 5'h00;
            fall_cnt_r <= 5'h00;
        end else if (fs_fall) begin
            rise_cnt_r <= 5'h00;
            fall_cnt_r <= 5'h00;
        end else begin
            if (sck_rise && rise_cnt_r != `ASFC_RISE_WORD) begin
                rise_cnt_r <= rise_cnt_r + 5'h01;
            end
            if (sck_fall && fall_cnt_r != `ASFC_FALL_END) begin
                fall_cnt_r <= fall_cnt_r + 5'h01;
            end
        end
    end

    // ****************************************************************
    // Command word capture and decode
    // ****************************************************************
    logic [15:0]       cmd_sr_r;
    logic [3:0]        pend_ch_r;
    logic [NPINS-1:0]  gpo_data_r;
    logic              gpi_read_en_r;
    logic              cmd_done;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cmd_sr_r <= 16'h0000;
        end else if (sck_rise && rise_cnt_r != `ASFC_RISE_WORD) begin
            cmd_sr_r <= {cmd_sr_r[14:0], sdi_s};
        end
    end

    // Only a full sixteen-clock frame commits its command
    assign cmd_done = fs_rise && rise_cnt_r == `ASFC_RISE_WORD
                      && fall_cnt_r == `ASFC_FALL_END;

    // Manual mode decode; the program bit gates channel, range and read enable
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pend_ch_r     <= `ASFC_CHANNEL_RST;
            range_sel     <= 1'b0;
            gpi_read_en_r <= 1'b0;
            gpo_data_r    <= '0;
        end else if (cmd_done && cmd_sr_r[`ASFC_CMD_MODE_MSB:`ASFC_CMD_MODE_LSB]
                     == `ASFC_CMD_MODE_MANUAL) begin
            gpo_data_r <= cmd_sr_r[NPINS-1:`ASFC_CMD_GPO_LSB];
            if (cmd_sr_r[`ASFC_CMD_PROG_BIT]) begin
                pend_ch_r     <= cmd_sr_r[`ASFC_CMD_CH_MSB:`ASFC_CMD_CH_LSB];
                range_sel     <= cmd_sr_r[`ASFC_CMD_RANGE_BIT];
                gpi_read_en_r <= cmd_sr_r[`ASFC_CMD_GPI_BIT];
            end
        end
    end

    // ****************************************************************
    // Sampling, multiplexer and acquisition
    // ****************************************************************
    logic [3:0]        samp_ch_r;
    logic [11:0]       samp_res_r;
    logic              samp_valid_r;
    logic              conv_seen_r;
    logic [NPINS-1:0]  gpi_latch_r;

    // Frame start catches channel, result and pin levels together
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            samp_ch_r    <= `ASFC_CHANNEL_RST;
            samp_res_r   <= 12'h000;
            samp_valid_r <= 1'b0;
            gpi_latch_r  <= '0;
            sample_pulse <= 1'b0;
        end else begin
            sample_pulse <= fs_fall;
            if (fs_fall) begin
                samp_ch_r    <= mux_channel;
                samp_res_r   <= conv_result;
                samp_valid_r <= conv_seen_r;
                gpi_latch_r  <= pin_s;
            end
        end
    end

    // Results are trusted once the first conversion after reset has completed
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            conv_seen_r <= 1'b0;
        end else if (sck_fall && fall_cnt_r == `ASFC_FALL_END - 5'h01) begin
            conv_seen_r <= 1'b1;
        end
    end

    // Channel change lands mid-frame so the new input settles before acquisition
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mux_channel <= `ASFC_CHANNEL_RST;
        end else if (sck_fall && fall_cnt_r == `ASFC_FALL_MUX - 5'h01) begin
            mux_channel <= pend_ch_r;
        end
    end

    // Busy from frame start to the sixteenth fall; acquisition until next start
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            conv_busy <= 1'b0;
            acquire   <= 1'b0;
        end else if (fs_fall) begin
            conv_busy <= 1'b1;
            acquire   <= 1'b0;
        end else begin
            // A cut frame drops busy at once, as its conversion never completes
            if (fs_rise || (sck_fall && fall_cnt_r == `ASFC_FALL_END - 5'h01)) begin
                conv_busy <= 1'b0;
            end
            if (sck_rise && rise_cnt_r == `ASFC_RISE_ACQ - 5'h01) begin
                acquire <= 1'b1;
            end
        end
    end

    // ****************************************************************
    // Serial output
    // ****************************************************************
    logic [14:0] out_sr_r;
    logic [3:0]  addr_field;
    logic [11:0] res_field;

    assign addr_field = gpi_read_en_r ? 4'(pin_s) : mux_channel;
    assign res_field  = conv_seen_r ? conv_result : 12'h000;

    // Word leaves MSB first: one bit at frame start, the rest on falls
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sdo      <= 1'b0;
            sdo_oe   <= 1'b0;
            out_sr_r <= 15'h0000;
        end else if (fs_fall) begin
            sdo      <= addr_field[3];
            sdo_oe   <= 1'b1;
            out_sr_r <= {addr_field[2:0], res_field};
        end else if (fs_rise) begin
            sdo_oe <= 1'b0;
        end else if (sck_fall && fall_cnt_r == `ASFC_FALL_END - 5'h01) begin
            sdo_oe <= 1'b0;
        end else if (sck_fall && fall_cnt_r < `ASFC_FALL_END - 5'h01) begin
            sdo      <= out_sr_r[14];
            out_sr_r <= {out_sr_r[13:0], 1'b0};
        end
    end

    // ****************************************************************
    // Alarms and general-purpose pins
    // ****************************************************************
    logic [11:0]  thr_hi_r [NCH];
    logic [11:0]  thr_lo_r [NCH];
    logic [7:0]   gpio_cfg_r;
    logic         hit_hi;
    logic         hit_lo;
    logic         alarm_hi_r;
    logic         alarm_lo_r;
    logic [NPINS-1:0] gpo_val_r;

    asfc_alarm_cmp #(.W(12)) u_alarm_cmp (
        .value  (samp_res_r),
        .thr_hi (thr_hi_r[samp_ch_r]),
        .thr_lo (thr_lo_r[samp_ch_r]),
        .over   (hit_hi),
        .under  (hit_lo)
    );

    // Clear on the tenth fall, then re-arm on the twelfth for this frame's result
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            alarm_hi_r <= 1'b0;
            alarm_lo_r <= 1'b0;
        end else if (sck_fall && fall_cnt_r == `ASFC_FALL_ALARM_CLR - 5'h01) begin
            alarm_hi_r <= 1'b0;
            alarm_lo_r <= 1'b0;
        end else if (sck_fall && fall_cnt_r == `ASFC_FALL_ALARM_SET - 5'h01) begin
            alarm_hi_r <= hit_hi & samp_valid_r;
            alarm_lo_r <= hit_lo & samp_valid_r;
        end
    end

    // Output data refreshes only at frame start
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gpo_val_r <= '0;
        end else if (fs_fall) begin
            gpo_val_r <= gpo_data_r;
        end
    end

    // Pin zero carries the high alarm, pin one the low alarm, when so assigned
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gpio_out <= '0;
            gpio_oe  <= '0;
        end else begin
            for (int i = 0; i < NPINS; i++) begin
                unique case (asfc_pkg::asfc_pin_cfg_t'(gpio_cfg_r[2*i +: 2]))
                    asfc_pkg::PIN_OUTPUT: begin
                        gpio_out[i] <= gpo_val_r[i];
                        gpio_oe[i]  <= 1'b1;
                    end
                    asfc_pkg::PIN_FUNCTION: begin
                        gpio_out[i] <= (i == 0) ? alarm_hi_r : (i == 1) ? alarm_lo_r : 1'b0;
                        gpio_oe[i]  <= (i < 2);
                    end
                    asfc_pkg::PIN_INPUT, asfc_pkg::PIN_UNUSED: begin
                        gpio_out[i] <= 1'b0;
                        gpio_oe[i]  <= 1'b0;
                    end
                endcase
            end
        end
    end

    // ****************************************************************
    // APB slave: one wait state, write lands on the completing edge
    // ****************************************************************
    logic       acc;
    logic       is_thr;
    logic [3:0] thr_idx;

    assign acc     = psel & penable;
    assign is_thr  = (paddr & `ASFC_THRESH_MASK) == `ASFC_THRESH_BASE;
    assign thr_idx = paddr[5:2];

    // Ready rises one cycle into the access phase and drops after completion
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else if (acc && !pready) begin
            pready  <= 1'b1;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
            if (is_thr) begin
                if (!pwrite) begin
                    prdata <= {4'h0, thr_hi_r[thr_idx], 4'h0, thr_lo_r[thr_idx]};
                end
            end else begin
                unique case (paddr)
                    `ASFC_STATUS_OFS: begin
                        if (!pwrite) begin
                            prdata <= {12'h000, 4'(gpi_latch_r), 3'h0, samp_valid_r,
                                       alarm_lo_r, alarm_hi_r, range_sel, gpi_read_en_r,
                                       samp_ch_r, mux_channel};
                        end
                    end
                    `ASFC_GPIO_CFG_OFS: begin
                        if (!pwrite) begin
                            prdata <= {24'h00_0000, gpio_cfg_r};
                        end
                    end
                    `ASFC_RESULT_OFS: begin
                        if (!pwrite) begin
                            prdata <= {16'h0000, samp_ch_r, samp_res_r};
                        end
                    end
                    default: begin
                        pslverr <= 1'b1;
                    end
                endcase
            end
        end else begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end
    end

    // Writable registers; status and result words ignore writes
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gpio_cfg_r <= `ASFC_GPIO_CFG_RST;
            for (int c = 0; c < NCH; c++) begin
                thr_hi_r[c] <= `ASFC_THR_HI_RST;
                thr_lo_r[c] <= `ASFC_THR_LO_RST;
            end
        end else if (acc && pready && pwrite) begin
            if (is_thr) begin
                thr_hi_r[thr_idx] <= pwdata[`ASFC_THR_HI_MSB:`ASFC_THR_HI_LSB];
                thr_lo_r[thr_idx] <= pwdata[`ASFC_THR_LO_MSB:`ASFC_THR_LO_LSB];
            end else if (paddr == `ASFC_GPIO_CFG_OFS) begin
                gpio_cfg_r <= pwdata[7:0];
            end
        end
    end

endmodule : asfc_top

//--- shared/asfc_defines.svh
// Offsets, field positions, reset values and edge counts of the serial frame control
`ifndef ASFC_DEFINES_SVH
`define ASFC_DEFINES_SVH

// ****************************************************************
// Register offsets (byte addresses, one 32-bit word each)
// ****************************************************************
`define ASFC_STATUS_OFS      8'h00
`define ASFC_GPIO_CFG_OFS    8'h04
`define ASFC_RESULT_OFS      8'h08
`define ASFC_THRESH_BASE     8'h40
`define ASFC_THRESH_MASK     8'hC3

// ****************************************************************
// Register field positions
// ****************************************************************
`define ASFC_THR_HI_MSB      27
`define ASFC_THR_HI_LSB      16
`define ASFC_THR_LO_MSB      11
`define ASFC_THR_LO_LSB      0

// ****************************************************************
// Command word layout on the serial input
// ****************************************************************
`define ASFC_CMD_MODE_MSB    15
`define ASFC_CMD_MODE_LSB    12
`define ASFC_CMD_MODE_MANUAL 4'h1
`define ASFC_CMD_PROG_BIT    11
`define ASFC_CMD_CH_MSB      10
`define ASFC_CMD_CH_LSB      7
`define ASFC_CMD_RANGE_BIT   6
`define ASFC_CMD_GPI_BIT     4
`define ASFC_CMD_GPO_MSB     3
`define ASFC_CMD_GPO_LSB     0

// ****************************************************************
// Reset values
// ****************************************************************
`define ASFC_CHANNEL_RST     4'h0
`define ASFC_GPIO_CFG_RST    8'h00
`define ASFC_THR_HI_RST      12'hFFF
`define ASFC_THR_LO_RST      12'h000

// ****************************************************************
// Serial clock edge numbers within a frame (1 = first edge)
// ****************************************************************
`define ASFC_FALL_MUX        5'h02
`define ASFC_FALL_ALARM_CLR  5'h0A
`define ASFC_FALL_ALARM_SET  5'h0C
`define ASFC_FALL_END        5'h10
`define ASFC_RISE_ACQ        5'h0E
`define ASFC_RISE_WORD       5'h10

`endif

//--- shared/asfc_pkg.sv
// Types shared by the serial frame control design
package asfc_pkg;

    // Frame progress as seen through the sampled frame select and serial clock
    typedef enum logic [1:0] {
        FRM_IDLE,
        FRM_SHIFT,
        FRM_WAIT
    } asfc_frame_state_t;

    // Per-pin configuration of the general-purpose pins
    typedef enum logic [1:0] {
        PIN_INPUT,
        PIN_OUTPUT,
        PIN_FUNCTION,
        PIN_UNUSED
    } asfc_pin_cfg_t;

endpackage : asfc_pkg

//--- src/asfc_sync.sv
// Two flip-flop synchroniser for a group of pin inputs
`timescale 1ns/1ps
module asfc_sync #(
    parameter int                 WIDTH   = 1,
    parameter logic [WIDTH-1:0]   RST_VAL = '0
) (
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic [WIDTH-1:0] d,
    output logic      [WIDTH-1:0] q
);

    logic [WIDTH-1:0] meta_r;

    // First stage feeds only the second stage
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_r <= RST_VAL;
            q      <= RST_VAL;
        end else begin
            meta_r <= d;
            q      <= meta_r;
        end
    end

endmodule : asfc_sync

//--- src/asfc_alarm_cmp.sv
// Window comparator of one conversion result against its high and low limits
`timescale 1ns/1ps
module asfc_alarm_cmp #(
    parameter int             W = 12
) (
    input  wire logic [W-1:0] value,
    input  wire logic [W-1:0] thr_hi,
    input  wire logic [W-1:0] thr_lo,
    output logic              over,
    output logic              under
);

    // Strict compare: a result equal to a limit is not an alarm
    assign over  = value > thr_hi;
    assign under = value < thr_lo;

endmodule : asfc_alarm_cmp

//--- testbench/asfc_monitor.sv
// Checker of the serial frame timing seen at the control block ports
`timescale 1ns/1ps
module asfc_monitor (
    input wire logic       pclk,
    input wire logic       presetn,
    input wire logic       frame_select_n,
    input wire logic       sample_pulse,
    input wire logic       conv_busy,
    input wire logic       acquire,
    input wire logic       sdo_oe,
    input wire logic [3:0] mux_channel
);
    // ****************************************
    // Frame timing properties
    // ****************************************
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Sync latency is about three clocks, so allow up to six
    property p_fs_busy; $fell(frame_select_n) |-> ##[2:6] conv_busy; endproperty
    a_fs_busy: assert property (p_fs_busy) else $error("busy late");
    property p_pulse_one; sample_pulse |=> !sample_pulse; endproperty
    a_pulse_one: assert property (p_pulse_one) else $error("long pulse");
    property p_busy_pulse; $rose(conv_busy) |-> ##[0:2] sample_pulse; endproperty
    a_busy_pulse: assert property (p_busy_pulse) else $error("no sample");
    property p_busy_len; $rose(conv_busy) |=> conv_busy [*8]; endproperty
    a_busy_len: assert property (p_busy_len) else $error("short busy");
    property p_acq_drop; $rose(conv_busy) |-> !acquire; endproperty
    a_acq_drop: assert property (p_acq_drop) else $error("acquire held");
    property p_acq_end; $fell(acquire) |-> conv_busy; endproperty
    a_acq_end: assert property (p_acq_end) else $error("acquire end");
    // Only a completed frame ends busy with select still low
    property p_oe_rel; $fell(conv_busy) && !frame_select_n |-> ##[0:1] !sdo_oe; endproperty
    a_oe_rel: assert property (p_oe_rel) else $error("sdo kept");
    property p_oe_idle; frame_select_n [*6] |-> !sdo_oe; endproperty
    a_oe_idle: assert property (p_oe_idle) else $error("sdo idle");
    property p_mux_frame; $changed(mux_channel) |-> conv_busy; endproperty
    a_mux_frame: assert property (p_mux_frame) else $error("mux moved");
    c_frame: cover property (sample_pulse);
    c_acq: cover property ($rose(acquire));
    c_mux: cover property ($changed(mux_channel));
endmodule : asfc_monitor

bind asfc_top asfc_monitor u_mon (.pclk, .presetn, .frame_select_n, .sample_pulse,
    .conv_busy, .acquire, .sdo_oe, .mux_channel);

//--- testbench/asfc_host.sv
// Host serial port model: frame select, idle-low serial clock, command words
`timescale 1ns/1ps
module asfc_host (
    output logic     frame_select_n,
    output logic     sclk,
    output logic     sdi,
    input wire logic sdo_w
);
    // Clock stands still low outside frames
    initial begin
        frame_select_n = 1'b1;
        sclk = 1'b0;
        sdi = 1'b0;
    end
    // One frame of n clocks; fewer than 16 cuts it short on purpose
    task automatic frame(input logic [15:0] cmd, input int n, output logic [15:0] rx);
        rx = 16'h0000;
        // Non-blocking pin updates, so the pclk sampler never races them
        frame_select_n <= 1'b0;
        #100;
        for (int i = 0; i < n; i++) begin
            #50 sdi <= cmd[15-i];
            #50 sclk <= 1'b1;
            rx[15-i] = sdo_w;
            #100 sclk <= 1'b0;
        end
        #100 frame_select_n <= 1'b1;
        sdi <= ~sdi;
        #200;
    endtask : frame
endmodule : asfc_host

//--- testbench/asfc_top_bench.sv
// Self-checking bench: APB accesses and serial frames through the host model
`timescale 1ns/1ps
`include "asfc_defines.svh"
module asfc_top_bench;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata, rd;
    logic        pready, pslverr, slv, sdo, sdo_oe, frame_select_n, sclk, sdi, range_sel;
    logic [11:0] conv_result = 12'h000;
    logic [3:0]  ext = 4'h0;
    logic [3:0]  gpio_out, gpio_oe, mux_channel;
    logic [15:0] rx;
    int          err_count = 0;
    int          comparisons = 0;
    // Pin level: driven value where enabled, outside level elsewhere
    wire  [3:0]  gpio_in = (gpio_oe & gpio_out) | (~gpio_oe & ext);
    wire         sdo_w = sdo_oe ? sdo : 1'bz;
    logic [15:0] cmd [5] = '{16'h1A8A, 16'h1BD5, 16'h1B85, 16'h19C0, 16'h1C80};
    logic [4:0]  erg = 5'b00010;
    logic [11:0] res [5] = '{12'h123, 12'h9AB, 12'h050, 12'h000, 12'h7FF};
    logic [15:0] erx [5] = '{16'h0000, 16'h09AB, 16'h9050, 16'h0000, 16'h77FF};
    logic [3:0]  emx [5] = '{4'h0, 4'h5, 4'h7, 4'h7, 4'h7};
    logic [2:0]  egp [5] = '{3'h0, 3'h1, 3'h6, 3'h0, 3'h4};

    always #12.5 pclk = ~pclk;
    asfc_top dut (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata,
        .pready, .pslverr, .frame_select_n, .sclk, .sdi, .sdo, .sdo_oe, .gpio_in,
        .gpio_out, .gpio_oe, .conv_result, .sample_pulse(), .conv_busy(), .acquire(),
        .mux_channel, .range_sel);
    asfc_host host (.frame_select_n, .sclk, .sdi, .sdo_w);

    // ****************************************
    // Tasks
    // ****************************************
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    // Request held until pready is seen high; the wait is bounded
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 40);
        rd = prdata;
        slv = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 40) err_count++;
    endtask : apb
    task conclude;
        $display("comparisons %0d mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : conclude

    // ****************************************
    // Tests
    // ****************************************
    initial begin
        #100us;
        err_count++;
        conclude();
    end
    initial begin
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, `ASFC_GPIO_CFG_OFS, 32'h0000_0000);
        check("cfg_rst", rd, 32'(`ASFC_GPIO_CFG_RST));
        check("mux_rst", 32'(mux_channel), 32'h0000_0000);
        apb(1'b0, `ASFC_THRESH_BASE, 32'h0000_0000);
        check("thr_rst", rd, {4'h0, `ASFC_THR_HI_RST, 4'h0, `ASFC_THR_LO_RST});
        apb(1'b0, 8'h20, 32'h0000_0000);
        check("unmapped", 32'(slv), 32'h0000_0001);
        apb(1'b1, `ASFC_GPIO_CFG_OFS, 32'h0000_001A);
        apb(1'b0, `ASFC_GPIO_CFG_OFS, 32'h0000_0000);
        check("cfg", rd, 32'h0000_001A);
        check("pin_oe", 32'(gpio_oe), 32'h0000_0007);
        apb(1'b1, `ASFC_THRESH_BASE, 32'h0800_0100);
        apb(1'b1, `ASFC_THRESH_BASE + 8'h14, 32'h0FFF_0100);
        $display("register test done");
        // Frame 3 is cut short; its command must leave no trace
        for (int i = 0; i < 5; i++) begin
            @(posedge pclk);
            conv_result <= res[i];
            ext <= (i == 2) ? 4'h8 : 4'h0;
            repeat (4) @(posedge pclk);
            host.frame(cmd[i], (i == 3) ? 5 : 16, rx);
            repeat (8) @(posedge pclk);
            check("oe", 32'(sdo_oe), 32'h0000_0000);
            check("mux", 32'(mux_channel), 32'(emx[i]));
            check("range", 32'(range_sel), 32'(erg[i]));
            if (i != 3) begin
                check("word", 32'(rx), 32'(erx[i]));
                check("pins", 32'(gpio_out[2:0]), 32'(egp[i]));
            end
            $display("frame test %0d done", i);
        end
        apb(1'b0, `ASFC_RESULT_OFS, 32'h0000_0000);
        check("result", rd, 32'h0000_77FF);
        apb(1'b0, `ASFC_STATUS_OFS, 32'h0000_0000);
        check("valid", 32'(rd[12]), 32'h0000_0001);
        $display("status test done");
        conclude();
    end
endmodule : asfc_top_bench
